/* hw/vol_ctrl_defines.svh */
// offsets, reset values, field positions and timing counts
// assumes a 50 MHz clock
`ifndef VOL_CTRL_DEFINES_SVH
`define VOL_CTRL_DEFINES_SVH

`define ADDR_MASTER_VOL 8'h07
`define ADDR_CH1_VOL 8'h08
`define ADDR_CH2_VOL 8'h09
`define ADDR_FINE_VOL 8'h0a
`define ADDR_SLEW_CFG 8'h0e
`define ADDR_MOD_LIMIT 8'h10
`define ADDR_OUT1_DLY 8'h11
`define ADDR_OUT2_DLY 8'h12
`define ADDR_OUT1_INV_DLY 8'h13
`define ADDR_OUT2_INV_DLY 8'h14
`define ADDR_SYS_CTRL 8'h05
`define ADDR_RATE_SEL 8'h15
`define ADDR_GAIN1 8'h16
`define ADDR_GAIN2 8'h17

`define RST_MASTER_VOL 8'hff
`define RST_CH_VOL 8'h30
`define RST_FINE_VOL 8'h00
`define RST_SLEW_CFG 8'h01
`define RST_MOD_LIMIT 8'h00
`define RST_DLY_CH1 8'hac
`define RST_DLY_CH2 8'h54
`define RST_SYS_CTRL 8'h40

`define VOL_MUTE 8'hff
`define VOL_MAX_VALID 8'hce
`define FINE_WE_BIT 7
`define SHUTDOWN_BIT 6

// step period in ns, cycles at 50 MHz rounded down
`define CLK_NS 20
`define STEP_NS_8K 125000
`define STEP_NS_11K 90700
`define STEP_NS_12K 83300
`define STEP_CYC_8K (`STEP_NS_8K / `CLK_NS)
`define STEP_CYC_11K (`STEP_NS_11K / `CLK_NS)
`define STEP_CYC_12K (`STEP_NS_12K / `CLK_NS)

`endif

/* hw/vol_ctrl_pkg.sv */
// types shared by the volume and delay control block
package vol_ctrl_pkg;
    typedef enum logic [1:0] {
        rate_8k = 2'b00,
        rate_11k = 2'b01,
        rate_12k = 2'b10
    } rate_family_t;

    typedef enum logic [1:0] {
        ramp_idle = 2'b00,
        ramp_run = 2'b01
    } ramp_state_t;
endpackage

/* hw/step_timer.sv */
// step tick generator: one pulse per ramp step period
// assumes the period counts fit in 16 bits
`timescale 1ns/1ns
module step_timer
    import vol_ctrl_pkg::*;
#(
    parameter int CYC_8K = 6250,
    parameter int CYC_11K = 4535,
    parameter int CYC_12K = 4165
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] rate_in,
    output logic tick_out
);
    initial begin
        if (CYC_8K < 2 || CYC_8K > 65535 || CYC_11K < 2 || CYC_12K < 2)
            $error("step_timer: step period out of range");
    end

    logic [15:0] count;
    wire [15:0] period = (rate_in == rate_11k) ? 16'(CYC_11K - 1) :
                         (rate_in == rate_12k) ? 16'(CYC_12K - 1) :
                         16'(CYC_8K - 1);
    wire wrap = (count >= period);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            count <= wrap ? 16'h0000 : count + 16'h0001;
            tick_out <= wrap;
        end
    end
endmodule

/* hw/gain_ramp.sv */
// one channel gain ramp: walks current gain to target in equal
// steps of span over slew length, one step per timer tick
// assumes gain in units of 0.125 dB attenuation, mute as max
`timescale 1ns/1ns
module gain_ramp
    import vol_ctrl_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic [W-1:0] target_in,
    input wire logic [W-1:0] mute_in,
    input wire logic [1:0] slew_in,
    output logic [W-1:0] gain_out,
    output logic busy_out
);
    initial begin
        if (W < 11) $error("gain_ramp: width too small");
    end

    ramp_state_t state;
    logic [W-1:0] start;
    logic [11:0] steps_left;
    logic [W-1:0] span;
    logic [11:0] total;
    // ramp length: 512, 1024, 2048, 256 steps
    assign total = (slew_in == 2'b00) ? 12'd512 :
                   (slew_in == 2'b01) ? 12'd1024 :
                   (slew_in == 2'b10) ? 12'd2048 : 12'd256;
    // span from the ramp's start point keeps each step the same size
    wire up = (target_in > start);
    assign span = up ? target_in - start : start - target_in;
    wire [11:0] done_steps = total - steps_left + 12'd1;
    wire [W+11:0] done_part = (W+12)'(span) * (W+12)'(done_steps);
    wire [W-1:0] moved = W'(done_part / (W+12)'(total));
    wire [W-1:0] next_gain = (steps_left <= 12'd1) ? target_in :
                             up ? start + moved : start - moved;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= ramp_idle;
            gain_out <= mute_in;
            start <= mute_in;
            steps_left <= 12'h000;
            busy_out <= 1'b0;
        end else begin
            case (state)
                ramp_idle: begin
                    if (target_in != gain_out) begin
                        state <= ramp_run;
                        start <= gain_out;
                        steps_left <= total;
                        busy_out <= 1'b1;
                    end
                end
                ramp_run: begin
                    if (tick_in) begin
                        gain_out <= next_gain;
                        steps_left <= steps_left - 12'h001;
                        if (steps_left <= 12'd1) begin
                            state <= ramp_idle;
                            busy_out <= 1'b0;
                        end
                    end
                end
                default: state <= ramp_idle;
            endcase
        end
    end
endmodule

/* hw/volume_ramp_pwm_delay_ctrl.sv */
// volume, ramp and pwm edge skew control registers
// assumes the serial control port decodes to a plain register port
`timescale 1ns/1ns
`include "vol_ctrl_defines.svh"
module volume_ramp_pwm_delay_ctrl
    import vol_ctrl_pkg::*;
#(
    parameter int GAIN_W = 12
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic [GAIN_W-1:0] ch1_atten_out,
    output logic [GAIN_W-1:0] ch2_atten_out,
    output logic ch1_silent_out,
    output logic ch2_silent_out,
    output logic ramp_busy_out,
    output logic [2:0] mod_limit_out,
    output logic signed [7:0] out1_skew_out,
    output logic signed [7:0] out2_skew_out,
    output logic signed [7:0] out1_inv_skew_out,
    output logic signed [7:0] out2_inv_skew_out,
    output logic shutdown_out
);
    initial begin
        if (GAIN_W < 12 || GAIN_W > 16)
            $error("volume_ramp_pwm_delay_ctrl: GAIN_W out of range");
    end

    ////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] master_volume;
    logic [7:0] channel_one_volume;
    logic [7:0] channel_two_volume;
    logic [7:0] master_fine_volume;
    logic [7:0] volume_slew_config;
    logic [7:0] modulation_depth_limit;
    logic [7:0] out1_edge_delay;
    logic [7:0] out2_edge_delay;
    logic [7:0] out1_inv_edge_delay;
    logic [7:0] out2_inv_edge_delay;
    logic [7:0] system_control;
    logic [1:0] rate_family;

    wire wr_master = wr_in && addr_in == `ADDR_MASTER_VOL;
    wire wr_ch1 = wr_in && addr_in == `ADDR_CH1_VOL;
    wire wr_ch2 = wr_in && addr_in == `ADDR_CH2_VOL;
    // fine write only with the enable bit set
    wire wr_fine = wr_in && addr_in == `ADDR_FINE_VOL &&
                   wdata_in[`FINE_WE_BIT];
    wire wr_slew = wr_in && addr_in == `ADDR_SLEW_CFG;
    wire wr_limit = wr_in && addr_in == `ADDR_MOD_LIMIT;
    wire wr_d1 = wr_in && addr_in == `ADDR_OUT1_DLY;
    wire wr_d2 = wr_in && addr_in == `ADDR_OUT2_DLY;
    wire wr_d1i = wr_in && addr_in == `ADDR_OUT1_INV_DLY;
    wire wr_d2i = wr_in && addr_in == `ADDR_OUT2_INV_DLY;
    wire wr_sys = wr_in && addr_in == `ADDR_SYS_CTRL;
    wire wr_rate = wr_in && addr_in == `ADDR_RATE_SEL;

    // one short block per register: reset value, then write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            master_volume <= `RST_MASTER_VOL;
        end else if (wr_master) begin
            master_volume <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            channel_one_volume <= `RST_CH_VOL;
        end else if (wr_ch1) begin
            channel_one_volume <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            channel_two_volume <= `RST_CH_VOL;
        end else if (wr_ch2) begin
            channel_two_volume <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            master_fine_volume <= `RST_FINE_VOL;
        end else if (wr_fine) begin
            master_fine_volume <= {1'b0, 5'h00, wdata_in[1:0]};
        end
    end

    // bit 2 codes are reserved, only the step count bits are kept
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            volume_slew_config <= `RST_SLEW_CFG;
        end else if (wr_slew) begin
            volume_slew_config <= {6'h00, wdata_in[1:0]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            modulation_depth_limit <= `RST_MOD_LIMIT;
        end else if (wr_limit) begin
            modulation_depth_limit <= {5'h00, wdata_in[2:0]};
        end
    end

    // low two delay bits are reserved zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out1_edge_delay <= `RST_DLY_CH1;
        end else if (wr_d1) begin
            out1_edge_delay <= {wdata_in[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out2_edge_delay <= `RST_DLY_CH2;
        end else if (wr_d2) begin
            out2_edge_delay <= {wdata_in[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out1_inv_edge_delay <= `RST_DLY_CH1;
        end else if (wr_d1i) begin
            out1_inv_edge_delay <= {wdata_in[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out2_inv_edge_delay <= `RST_DLY_CH2;
        end else if (wr_d2i) begin
            out2_inv_edge_delay <= {wdata_in[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            system_control <= `RST_SYS_CTRL;
        end else if (wr_sys) begin
            system_control <= {1'b0, wdata_in[6], 6'h00};
        end
    end

    // rate code 3 names no family and is dropped
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rate_family <= 2'h0;
        end else if (wr_rate && wdata_in[1:0] != 2'b11) begin
            rate_family <= wdata_in[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // gain arithmetic, units of 0.125 dB attenuation from +24 dB
    // coarse code counts 4 units, fine code subtracts 1 unit per count
    function automatic logic [GAIN_W-1:0] coarse_units(
        input logic [7:0] code);
        logic [7:0] c;
        c = (code > `VOL_MAX_VALID) ? `VOL_MAX_VALID : code;
        coarse_units = GAIN_W'({c, 2'b00});
    endfunction

    wire [GAIN_W-1:0] mute_units = {GAIN_W{1'b1}};
    wire [GAIN_W-1:0] master_units = coarse_units(master_volume);
    wire [GAIN_W-1:0] ch1_units = coarse_units(channel_one_volume);
    wire [GAIN_W-1:0] ch2_units = coarse_units(channel_two_volume);
    wire [GAIN_W-1:0] fine_units = GAIN_W'(master_fine_volume[1:0]);
    wire master_mute = master_volume == `VOL_MUTE;
    wire shutdown = system_control[`SHUTDOWN_BIT];

    // zero-dB reference sits at 48 coarse codes; sum then rebase
    wire [GAIN_W+1:0] sum1 = (GAIN_W+2)'(master_units) +
        (GAIN_W+2)'(ch1_units) + (GAIN_W+2)'(GAIN_W'(8'd192));
    wire [GAIN_W+1:0] sum2 = (GAIN_W+2)'(master_units) +
        (GAIN_W+2)'(ch2_units) + (GAIN_W+2)'(GAIN_W'(8'd192));
    wire [GAIN_W+1:0] base = (GAIN_W+2)'(GAIN_W'(9'd384)) +
        (GAIN_W+2)'(fine_units);
    wire [GAIN_W+1:0] att1 = (sum1 > base) ? sum1 - base : '0;
    wire [GAIN_W+1:0] att2 = (sum2 > base) ? sum2 - base : '0;
    wire [GAIN_W-1:0] sat1 = (att1 >= (GAIN_W+2)'(mute_units)) ?
        mute_units - 1'b1 : GAIN_W'(att1);
    wire [GAIN_W-1:0] sat2 = (att2 >= (GAIN_W+2)'(mute_units)) ?
        mute_units - 1'b1 : GAIN_W'(att2);

    // mute targets ramp at the same slew as any change
    wire mute1 = master_mute || channel_one_volume == `VOL_MUTE;
    wire mute2 = master_mute || channel_two_volume == `VOL_MUTE;
    wire [GAIN_W-1:0] target1 = mute1 ? mute_units : sat1;
    wire [GAIN_W-1:0] target2 = mute2 ? mute_units : sat2;

    ////////////////////////////////////////////////////////////////
    // ramp engine
    logic tick;
    logic [GAIN_W-1:0] gain1;
    logic [GAIN_W-1:0] gain2;
    logic busy1;
    logic busy2;

    step_timer #(
        .CYC_8K(`STEP_CYC_8K),
        .CYC_11K(`STEP_CYC_11K),
        .CYC_12K(`STEP_CYC_12K)
    ) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rate_in(rate_family),
        .tick_out(tick)
    );

    gain_ramp #(.W(GAIN_W)) u_ramp1 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .target_in(target1),
        .mute_in(mute_units),
        .slew_in(volume_slew_config[1:0]),
        .gain_out(gain1),
        .busy_out(busy1)
    );

    gain_ramp #(.W(GAIN_W)) u_ramp2 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tick_in(tick),
        .target_in(target2),
        .mute_in(mute_units),
        .slew_in(volume_slew_config[1:0]),
        .gain_out(gain2),
        .busy_out(busy2)
    );

    ////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr_in)
            `ADDR_MASTER_VOL: rd_mux = master_volume;
            `ADDR_CH1_VOL: rd_mux = channel_one_volume;
            `ADDR_CH2_VOL: rd_mux = channel_two_volume;
            `ADDR_FINE_VOL: rd_mux = master_fine_volume;
            `ADDR_SLEW_CFG: rd_mux = volume_slew_config;
            `ADDR_MOD_LIMIT: rd_mux = modulation_depth_limit;
            `ADDR_OUT1_DLY: rd_mux = out1_edge_delay;
            `ADDR_OUT2_DLY: rd_mux = out2_edge_delay;
            `ADDR_OUT1_INV_DLY: rd_mux = out1_inv_edge_delay;
            `ADDR_OUT2_INV_DLY: rd_mux = out2_inv_edge_delay;
            `ADDR_SYS_CTRL: rd_mux = system_control;
            `ADDR_RATE_SEL: rd_mux = {6'h00, rate_family};
            `ADDR_GAIN1: rd_mux = gain1[GAIN_W-1:GAIN_W-8];
            `ADDR_GAIN2: rd_mux = gain2[GAIN_W-1:GAIN_W-8];
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
            ch1_atten_out <= {GAIN_W{1'b1}};
            ch2_atten_out <= {GAIN_W{1'b1}};
            ch1_silent_out <= 1'b1;
            ch2_silent_out <= 1'b1;
            ramp_busy_out <= 1'b0;
            mod_limit_out <= 3'h0;
            out1_skew_out <= 8'sh00;
            out2_skew_out <= 8'sh00;
            out1_inv_skew_out <= 8'sh00;
            out2_inv_skew_out <= 8'sh00;
            shutdown_out <= 1'b1;
        end else begin
            rdata_out <= rd_in ? rd_mux : 8'h00;
            ch1_atten_out <= gain1;
            ch2_atten_out <= gain2;
            // silence at full mute or while shut down
            ch1_silent_out <= shutdown || gain1 == mute_units;
            ch2_silent_out <= shutdown || gain2 == mute_units;
            ramp_busy_out <= busy1 || busy2;
            mod_limit_out <= modulation_depth_limit[2:0];
            // skew in delay clocks: signed six bits times four
            out1_skew_out <= $signed(out1_edge_delay);
            out2_skew_out <= $signed(out2_edge_delay);
            out1_inv_skew_out <= $signed(out1_inv_edge_delay);
            out2_inv_skew_out <= $signed(out2_inv_edge_delay);
            shutdown_out <= shutdown;
        end
    end
endmodule

/* bench/volume_ramp_pwm_delay_ctrl_chk.sv */
// port assertions for the volume, ramp and edge skew register block
// assumes a bind to the block, one clock, synchronous reset
`timescale 1ns/1ns
module volume_ramp_pwm_delay_ctrl_chk #(
    parameter int GAIN_W = 12
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [GAIN_W-1:0] ch1_atten_out,
    input wire logic [GAIN_W-1:0] ch2_atten_out,
    input wire logic ch1_silent_out,
    input wire logic ch2_silent_out,
    input wire logic ramp_busy_out,
    input wire logic [2:0] mod_limit_out,
    input wire logic signed [7:0] out1_skew_out,
    input wire logic signed [7:0] out2_skew_out,
    input wire logic signed [7:0] out1_inv_skew_out,
    input wire logic signed [7:0] out2_inv_skew_out,
    input wire logic shutdown_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire wr_out1 = wr_in && addr_in == 8'h11;
    wire wr_out2i = wr_in && addr_in == 8'h14;
    wire wr_lim = wr_in && addr_in == 8'h10;
    wire wr_sys = wr_in && addr_in == 8'h05;
    ////////////////////////////////////////////////////////////////////////
    skew_low_zero_a: assert property (
        (out1_skew_out[1:0] | out2_skew_out[1:0] | out1_inv_skew_out[1:0]
        | out2_inv_skew_out[1:0]) == 2'b00) else $error("skew low bits set");
    read_idle_zero_a: assert property (
        !$past(rd_in) |-> rdata_out == 8'h00) else $error("rdata not idle");
    out1_delay_map_a: assert property (
        wr_out1 ##1 !wr_out1 |=> out1_skew_out == ($past(wdata_in, 2) & 8'hfc))
        else $error("out1 skew mismatch");
    out2_inv_map_a: assert property (
        wr_out2i ##1 !wr_out2i
        |=> out2_inv_skew_out == ($past(wdata_in, 2) & 8'hfc))
        else $error("out2 inv skew mismatch");
    limit_map_a: assert property (
        wr_lim ##1 !wr_lim |=> mod_limit_out == $past(wdata_in[2:0], 2))
        else $error("limit mismatch");
    shut_silent_a: assert property (
        shutdown_out && $past(shutdown_out)
        |-> ch1_silent_out && ch2_silent_out)
        else $error("not silent in shutdown");
    shut_cause_a: assert property (
        $changed(shutdown_out) |-> $past(wr_sys) || $past(wr_sys, 2))
        else $error("shutdown changed unasked");
    atten_ramp_a: assert property (
        $changed(ch1_atten_out) |-> ramp_busy_out || $past(ramp_busy_out))
        else $error("gain moved outside ramp");
    fine_rsvd_a: assert property (
        rd_in && addr_in == 8'h0a |=> rdata_out[7:2] == 6'h00)
        else $error("fine reserved bits set");
    slew_rsvd_a: assert property (
        rd_in && addr_in == 8'h0e |=> rdata_out[7:2] == 6'h00)
        else $error("slew reserved bits set");
    skew_write_c: cover property (wr_out1 ##1 !wr_out1);
    ramp_run_c: cover property ($rose(ramp_busy_out));
    shut_exit_c: cover property ($fell(shutdown_out));
endmodule
bind volume_ramp_pwm_delay_ctrl volume_ramp_pwm_delay_ctrl_chk #(
    .GAIN_W(GAIN_W)) chk (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ch1_atten_out(ch1_atten_out),
    .ch2_atten_out(ch2_atten_out), .ch1_silent_out(ch1_silent_out),
    .ch2_silent_out(ch2_silent_out), .ramp_busy_out(ramp_busy_out),
    .mod_limit_out(mod_limit_out), .out1_skew_out(out1_skew_out),
    .out2_skew_out(out2_skew_out), .out1_inv_skew_out(out1_inv_skew_out),
    .out2_inv_skew_out(out2_inv_skew_out), .shutdown_out(shutdown_out));

/* bench/volume_ramp_pwm_delay_ctrl_tb.sv */
// self-checking bench for the volume, ramp and edge skew register block
// assumes the block's own step timer counts at 50 MHz
`timescale 1ns/1ns
module volume_ramp_pwm_delay_ctrl_tb;
    import vol_ctrl_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; $display("Error at %0t: got %h expected %h", \
    $time, g, e); end end
    typedef struct {logic wr; logic [7:0] a;
        logic [7:0] d; logic [7:0] e;} row_t;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic [11:0] ch1_atten_out, ch2_atten_out, old;
    logic ch1_silent_out, ch2_silent_out, ramp_busy_out, shutdown_out;
    logic [2:0] mod_limit_out;
    logic signed [7:0] out1_skew_out, out2_skew_out;
    logic signed [7:0] out1_inv_skew_out, out2_inv_skew_out;
    logic [7:0] rd;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    int steps [0:2] = '{6250, 4535, 4165};
    row_t rows [0:22] = '{
        '{0, 8'h07, 0, 8'hff}, '{0, 8'h08, 0, 8'h30}, '{0, 8'h09, 0, 8'h30},
        '{0, 8'h0a, 0, 8'h00}, '{0, 8'h0e, 0, 8'h01}, '{0, 8'h10, 0, 8'h00},
        '{0, 8'h11, 0, 8'hac}, '{0, 8'h12, 0, 8'h54}, '{0, 8'h13, 0, 8'hac},
        '{0, 8'h14, 0, 8'h54}, '{0, 8'h05, 0, 8'h40},
        '{1, 8'h0e, 8'hff, 8'h03}, '{1, 8'h10, 8'hff, 8'h07},
        '{1, 8'h0a, 8'h83, 8'h03}, '{1, 8'h0a, 8'h02, 8'h03},
        '{1, 8'h08, 8'h00, 8'h00}, '{1, 8'h09, 8'hce, 8'hce},
        '{1, 8'h11, 8'hb8, 8'hb8}, '{1, 8'h12, 8'h60, 8'h60},
        '{1, 8'h13, 8'ha0, 8'ha0}, '{1, 8'h14, 8'h48, 8'h48},
        '{1, 8'h20, 8'h55, 8'h00}, '{1, 8'h07, 8'h30, 8'h30}};
    volume_ramp_pwm_delay_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .ch1_atten_out(ch1_atten_out),
        .ch2_atten_out(ch2_atten_out), .ch1_silent_out(ch1_silent_out),
        .ch2_silent_out(ch2_silent_out), .ramp_busy_out(ramp_busy_out),
        .mod_limit_out(mod_limit_out), .out1_skew_out(out1_skew_out),
        .out2_skew_out(out2_skew_out), .out1_inv_skew_out(out1_inv_skew_out),
        .out2_inv_skew_out(out2_inv_skew_out), .shutdown_out(shutdown_out));
    always #10 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(shutdown_out, 1'b1)
        `CHK({ch1_silent_out, ch2_silent_out, ramp_busy_out}, 3'b110)
        `CHK(ch1_atten_out, 12'hfff)
        `CHK({out1_skew_out, out2_skew_out}, 16'hac54)
        `CHK({out1_inv_skew_out, out2_inv_skew_out}, 16'hac54)
    endtask
    // edges until channel one gain moves, bounded
    task automatic step_wait(output int k);
        k = 0;
        old = ch1_atten_out;
        while (ch1_atten_out === old && k < 8000) begin
            @(posedge clk_in);
            #1;
            k++;
        end
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr_reg(rows[i].a, rows[i].d);
            end
            rd_reg(rows[i].a, rd);
            `CHK(rd, rows[i].e)
        end
        `CHK({out1_skew_out, out2_skew_out}, 16'hb860)
        `CHK({out1_inv_skew_out, out2_inv_skew_out}, 16'ha048)
        `CHK(mod_limit_out, 3'h7)
        wr_reg(8'h05, 8'h00);
        // output register follows the stored bit one edge later
        @(posedge clk_in);
        #1;
        `CHK(shutdown_out, 1'b0)
        for (int r = 2; r >= 0; r--) begin
            wr_reg(8'h15, r[7:0]);
            // first moves may straddle the rate change
            repeat (3) step_wait(n);
            `CHK(n, steps[r])
            `CHK(ch1_atten_out < old, 1'b1)
            `CHK(ch1_atten_out < ch2_atten_out, 1'b1)
            `CHK({ramp_busy_out, ch1_silent_out}, 2'b10)
            `CHK({ch2_silent_out, ch2_atten_out < 12'hfff}, 2'b01)
        end
        do_reset();
        print_verdict();
    end
endmodule
